// >>> threshold_cmp_pkg.sv
// constants, types and register map of the scaled threshold comparator
// What this block does
// - mode picks greater, equal or less relation
// - reset leaves the comparator in less mode
// - parameter visibility bit resets to shown
// - each gain scales only its own input
// - offset added to scaled actual value
// - switch band applied on the releasing side of setpoint, both sides in equal mode
// - unconnected gains read one, offset/band zero
// - overflow flag on any out-of-range quantity
// - overflow forces the result contact open
// - three quantities checked against signed 32-bit
// - greater: close at setpoint, open below band
// - less: close at setpoint, open above band
// - equal: close when values are equal
// - equal: open outside the band either side
// - all operands are signed 32-bit integers
package threshold_cmp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WIDE_W = 66;

  localparam logic [ADDR_W-1:0] CTRL_OFFS     = 8'h00;
  localparam logic [ADDR_W-1:0] CONNECT_OFFS  = 8'h04;
  localparam logic [ADDR_W-1:0] ACTUAL_OFFS   = 8'h08;
  localparam logic [ADDR_W-1:0] SETPOINT_OFFS = 8'h0c;
  localparam logic [ADDR_W-1:0] AGAIN_OFFS    = 8'h10;
  localparam logic [ADDR_W-1:0] SGAIN_OFFS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFFSET_OFFS   = 8'h18;
  localparam logic [ADDR_W-1:0] BAND_OFFS     = 8'h1c;
  localparam logic [ADDR_W-1:0] STATUS_OFFS   = 8'h20;
  localparam logic [ADDR_W-1:0] PROC_ACT_OFFS = 8'h24;
  localparam logic [ADDR_W-1:0] PROC_SET_OFFS = 8'h28;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SHOW_BIT = 2;
  localparam int unsigned CONN_AGAIN    = 0;
  localparam int unsigned CONN_SGAIN    = 1;
  localparam int unsigned CONN_OFFSET   = 2;
  localparam int unsigned CONN_BAND     = 3;
  localparam int unsigned STAT_CONTACT  = 0;
  localparam int unsigned STAT_FLAG     = 1;
  localparam int unsigned STAT_LATCH    = 2;

  typedef enum logic [1:0] {
    mode_less    = 2'b00,
    mode_greater = 2'b01,
    mode_same    = 2'b10
  } mode_type;

  localparam logic [1:0]        MODE_RESET    = 2'b00;
  localparam logic              SHOW_RESET    = 1'b1;
  localparam logic [3:0]        CONNECT_RESET = 4'h0;
  localparam logic [DATA_W-1:0] GAIN_DEFAULT  = 32'h0000_0001;
  localparam logic [DATA_W-1:0] ZERO_DEFAULT  = 32'h0000_0000;

  typedef struct packed {
    logic signed [DATA_W-1:0] actual;
    logic signed [DATA_W-1:0] setpoint;
    logic signed [DATA_W-1:0] again;
    logic signed [DATA_W-1:0] sgain;
    logic signed [DATA_W-1:0] offset;
    logic signed [DATA_W-1:0] band;
  } operand_set_type;

endpackage

// >>> scaled_threshold_comparator.sv
// scaled threshold comparator with hysteresis, apb register slave
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
module scaled_threshold_comparator (
  input  wire  logic                                  pclk,
  input  wire  logic                                  presetn,
  input  wire  logic                                  psel,
  input  wire  logic                                  penable,
  input  wire  logic                                  pwrite,
  input  wire  logic [threshold_cmp_pkg::ADDR_W-1:0]  paddr,
  input  wire  logic [threshold_cmp_pkg::DATA_W-1:0]  pwdata,
  input  wire  logic [3:0]                            pstrb,
  output logic       [threshold_cmp_pkg::DATA_W-1:0]  prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire  logic                                  scan_strobe,
  output logic                                        compare_result_contact,
  output logic                                        range_overflow_flag,
  output logic                                        parameter_visible
);
  import threshold_cmp_pkg::*;

  localparam logic signed [WIDE_W-1:0] RANGE_MIN = -(66'sd2 ** 31);
  localparam logic signed [WIDE_W-1:0] RANGE_MAX = (66'sd2 ** 31) - 66'sd1;

  // configuration and operand storage
  mode_type              mode_reg;
  logic                  show_reg;
  logic [3:0]            connect_reg;
  operand_set_type       raw_reg;
  logic                  latch_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic [DATA_W-1:0]     prdata_reg;
  logic                  contact_reg;
  logic                  flag_reg;

  // combinational datapath
  operand_set_type         eff;
  logic signed [WIDE_W-1:0] proc_actual;
  logic signed [WIDE_W-1:0] proc_setpoint;
  logic signed [WIDE_W-1:0] band_hi;
  logic signed [WIDE_W-1:0] band_lo;
  logic                     overflow_now;
  logic                     latch_next;

  // bus decode
  logic                  access_start;
  logic                  access_done;
  logic                  addr_known;
  logic                  addr_writable;
  logic [DATA_W-1:0]     read_mux;

  // byte-lane merge of a write into a stored word
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [3:0]        lanes
  );
    logic [DATA_W-1:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // exact product plus addend, wide enough that nothing wraps
  function automatic logic signed [WIDE_W-1:0] scale_add(
    input logic signed [DATA_W-1:0] value,
    input logic signed [DATA_W-1:0] gain,
    input logic signed [DATA_W-1:0] addend
  );
    logic signed [WIDE_W-1:0] product;
    product = WIDE_W'(value) * WIDE_W'(gain);
    return product + WIDE_W'(addend);
  endfunction

  function automatic logic fits_word(input logic signed [WIDE_W-1:0] value);
    return (value >= RANGE_MIN) && (value <= RANGE_MAX);
  endfunction

  // an unconnected operand reads its default; shared by every optional input
  function automatic logic signed [DATA_W-1:0] pick_operand(
    input logic                     connected,
    input logic signed [DATA_W-1:0] value,
    input logic signed [DATA_W-1:0] fallback
  );
    logic signed [DATA_W-1:0] chosen;
    chosen = fallback;
    if (connected) begin
      chosen = value;
    end
    return chosen;
  endfunction

  // operand defaults when an input is left unconnected
  always_comb begin
    eff        = raw_reg;
    eff.again  = pick_operand(connect_reg[CONN_AGAIN], raw_reg.again, GAIN_DEFAULT);
    eff.sgain  = pick_operand(connect_reg[CONN_SGAIN], raw_reg.sgain, GAIN_DEFAULT);
    eff.offset = pick_operand(connect_reg[CONN_OFFSET], raw_reg.offset, ZERO_DEFAULT);
    eff.band   = pick_operand(connect_reg[CONN_BAND], raw_reg.band, ZERO_DEFAULT);
  end

  always_comb begin
    proc_actual   = scale_add(eff.actual, eff.again, eff.offset);
    proc_setpoint = scale_add(eff.setpoint, eff.sgain, ZERO_DEFAULT);
    band_hi       = scale_add(eff.setpoint, eff.sgain, eff.band);
    band_lo       = proc_setpoint - WIDE_W'(eff.band);
    // the bare scaled setpoint needs no own check: it lies between the band edges
    overflow_now  = !fits_word(proc_actual) || !fits_word(band_hi)
                    || !fits_word(band_lo);
  end

  // close condition of a mode: the processed actual value has reached the setpoint
  function automatic logic close_hit(
    input mode_type                 mode,
    input logic signed [WIDE_W-1:0] act_val,
    input logic signed [WIDE_W-1:0] set_val
  );
    logic hit;

    hit = 1'b0;
    unique case (mode)
      mode_greater: begin
        hit = (act_val >= set_val);
      end
      mode_same: begin
        hit = (act_val == set_val);
      end
      mode_less: begin
        hit = (act_val <= set_val);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // open condition of a mode: the value has left the band on the releasing side
  function automatic logic open_hit(
    input mode_type                 mode,
    input logic signed [WIDE_W-1:0] act_val,
    input logic signed [WIDE_W-1:0] hi_val,
    input logic signed [WIDE_W-1:0] lo_val
  );
    logic hit;

    hit = 1'b1;
    unique case (mode)
      mode_greater: begin
        hit = (act_val < lo_val);
      end
      mode_same: begin
        hit = (act_val > hi_val) || (act_val < lo_val);
      end
      mode_less: begin
        hit = (act_val > hi_val);
      end
      default: begin
        // an illegal code drops the contact rather than holding stale state
        hit = 1'b1;
      end
    endcase
    return hit;
  endfunction

  // hysteresis: between the close and open thresholds the contact holds
  always_comb begin
    latch_next = latch_reg;
    if (close_hit(mode_reg, proc_actual, proc_setpoint)) begin
      latch_next = 1'b1;
    end else if (open_hit(mode_reg, proc_actual, band_hi, band_lo)) begin
      latch_next = 1'b0;
    end
    // overflow also clears the held state, so recovery starts from open
    if (overflow_now) begin
      latch_next = 1'b0;
    end
  end

  // evaluation happens only on the scan strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg   <= 1'b0;
      contact_reg <= 1'b0;
      flag_reg    <= 1'b0;
    end else if (scan_strobe) begin
      latch_reg   <= latch_next;
      contact_reg <= latch_next && !overflow_now;
      flag_reg    <= overflow_now;
    end
  end

  // apb: one wait state; write and read data land at the ready edge
  assign access_start = psel && penable && !pready_reg;
  assign access_done  = psel && penable && pready_reg;

  always_comb begin
    addr_known    = 1'b1;
    addr_writable = 1'b1;
    read_mux      = '0;
    unique case (paddr)
      CTRL_OFFS: begin
        read_mux[CTRL_MODE_LSB +: 2] = mode_reg;
        read_mux[CTRL_SHOW_BIT]      = show_reg;
      end
      CONNECT_OFFS: begin
        read_mux[3:0] = connect_reg;
      end
      ACTUAL_OFFS: begin
        read_mux = raw_reg.actual;
      end
      SETPOINT_OFFS: begin
        read_mux = raw_reg.setpoint;
      end
      // gains, offset and band read back what the datapath really uses
      AGAIN_OFFS: begin
        read_mux = eff.again;
      end
      SGAIN_OFFS: begin
        read_mux = eff.sgain;
      end
      OFFSET_OFFS: begin
        read_mux = eff.offset;
      end
      BAND_OFFS: begin
        read_mux = eff.band;
      end
      STATUS_OFFS: begin
        addr_writable          = 1'b0;
        read_mux[STAT_CONTACT] = contact_reg;
        read_mux[STAT_FLAG]    = flag_reg;
        read_mux[STAT_LATCH]   = latch_reg;
      end
      PROC_ACT_OFFS: begin
        addr_writable = 1'b0;
        read_mux      = proc_actual[DATA_W-1:0];
      end
      PROC_SET_OFFS: begin
        addr_writable = 1'b0;
        read_mux      = proc_setpoint[DATA_W-1:0];
      end
      default: begin
        addr_known    = 1'b0;
        addr_writable = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg <= access_start;
      if (access_start) begin
        pslverr_reg <= pwrite ? !addr_writable : !addr_known;
        prdata_reg  <= pwrite ? '0 : read_mux;
      end else begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= '0;
      end
    end
  end

  // mode field of the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= mode_type'(MODE_RESET);
    end else if (access_done && pwrite && paddr == CTRL_OFFS && pstrb[0]) begin
      // the spare code is refused so the mode never leaves the legal set
      if (pwdata[CTRL_MODE_LSB +: 2] != 2'b11) begin
        mode_reg <= mode_type'(pwdata[CTRL_MODE_LSB +: 2]);
      end
    end
  end

  // parameter visibility bit of the control word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_reg <= SHOW_RESET;
    end else if (access_done && pwrite && paddr == CTRL_OFFS && pstrb[0]) begin
      show_reg <= pwdata[CTRL_SHOW_BIT];
    end
  end

  // connection mask; a cleared bit makes that operand read its default
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      connect_reg <= CONNECT_RESET;
    end else if (access_done && pwrite && paddr == CONNECT_OFFS && pstrb[0]) begin
      connect_reg <= pwdata[3:0];
    end
  end

  // operand writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_reg.actual   <= ZERO_DEFAULT;
      raw_reg.setpoint <= ZERO_DEFAULT;
      raw_reg.again    <= GAIN_DEFAULT;
      raw_reg.sgain    <= GAIN_DEFAULT;
      raw_reg.offset   <= ZERO_DEFAULT;
      raw_reg.band     <= ZERO_DEFAULT;
    end else if (access_done && pwrite) begin
      unique case (paddr)
        ACTUAL_OFFS: begin
          raw_reg.actual <= merge_bytes(raw_reg.actual, pwdata, pstrb);
        end
        SETPOINT_OFFS: begin
          raw_reg.setpoint <= merge_bytes(raw_reg.setpoint, pwdata, pstrb);
        end
        AGAIN_OFFS: begin
          raw_reg.again <= merge_bytes(raw_reg.again, pwdata, pstrb);
        end
        SGAIN_OFFS: begin
          raw_reg.sgain <= merge_bytes(raw_reg.sgain, pwdata, pstrb);
        end
        OFFSET_OFFS: begin
          raw_reg.offset <= merge_bytes(raw_reg.offset, pwdata, pstrb);
        end
        BAND_OFFS: begin
          raw_reg.band <= merge_bytes(raw_reg.band, pwdata, pstrb);
        end
        default: begin
          // read-only and unmapped offsets change nothing here
        end
      endcase
    end
  end

  assign prdata                 = prdata_reg;
  assign pready                 = pready_reg;
  assign pslverr                = pslverr_reg;
  assign compare_result_contact = contact_reg;
  assign range_overflow_flag    = flag_reg;
  assign parameter_visible      = show_reg;

endmodule

// >>> threshold_cmp_properties.sv
// port-level assertions for the scaled threshold comparator
`timescale 1ns/100ps
module threshold_cmp_properties import threshold_cmp_pkg::*; (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              scan_strobe,
  input wire logic              compare_result_contact,
  input wire logic              range_overflow_flag,
  input wire logic              parameter_visible
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OVF_OPEN: assert property (
    range_overflow_flag |-> !compare_result_contact) else $error("contact closed on overflow");
  AST_HOLD_OUTS: assert property (
    !scan_strobe |=> $stable({compare_result_contact, range_overflow_flag}))
    else $error("outputs moved without strobe");
  AST_RESET_OUTS: assert property (
    $rose(presetn) |-> !compare_result_contact && !range_overflow_flag)
    else $error("outputs not cleared by reset");
  AST_SHOW_RESET: assert property (
    $rose(presetn) |-> parameter_visible) else $error("visibility not shown after reset");
  AST_SHOW_WRITE: assert property (
    $changed(parameter_visible) |-> $past(pready && pwrite && paddr == CTRL_OFFS))
    else $error("visibility changed without control write");
  AST_WAIT_STATE: assert property (
    (psel && !penable) ##1 (psel && penable) |=> pready) else $error("ready not after one wait");
  AST_READY_PULSE: assert property (
    pready |=> !pready) else $error("ready held over one cycle");
  AST_RDATA_IDLE: assert property (
    !pready |-> prdata == '0) else $error("read data outside ready cycle");
  AST_ERR_READY: assert property (
    pslverr |-> pready && psel && penable) else $error("error outside access");
  cover property (scan_strobe ##1 compare_result_contact);
  cover property (scan_strobe ##1 range_overflow_flag);
  cover property (pready && pslverr);
endmodule

// >>> scan_source.sv
// control program model: issues scan strobes to the comparator
`timescale 1ns/100ps
module scan_source (
  input  wire logic pclk,
  output logic      scan_strobe
);
  initial scan_strobe = 1'b0;
  // single-cycle scan; contacts are read only between scans
  task automatic pulse();
    @(posedge pclk);
    scan_strobe <= 1'b1;
    @(posedge pclk);
    scan_strobe <= 1'b0;
  endtask
endmodule

// >>> scaled_threshold_comparator_tb_top.sv
// testbench top: apb master, scan source and checks
`timescale 1ns/100ps
module scaled_threshold_comparator_tb_top;
  import threshold_cmp_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0]        pstrb = 4'hf;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              scan_strobe;
  logic              compare_result_contact;
  logic              range_overflow_flag;
  logic              parameter_visible;
  logic [DATA_W-1:0] rd;
  logic              er;
  int                fail_count = 0;
  int                checks_done = 0;
  scaled_threshold_comparator u_dut (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pstrb                  (pstrb),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .scan_strobe            (scan_strobe),
    .compare_result_contact (compare_result_contact),
    .range_overflow_flag    (range_overflow_flag),
    .parameter_visible      (parameter_visible)
  );
  scan_source u_src (.pclk(pclk), .scan_strobe(scan_strobe));
  initial begin
    forever #4 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // request held until pready is sampled high; bounded wait
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("apb timeout", 1, 0);
      end_sim();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
    chk("write error", 0, er);
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    apb(1'b0, a, '0);
    chk("read data", e, rd);
  endtask
  // operands stay inside the signed 32-bit range
  task automatic step(input logic [DATA_W-1:0] a, input logic c, input logic f);
    wr(ACTUAL_OFFS, a);
    u_src.pulse();
    @(negedge pclk);
    chk("contact", c, compare_result_contact);
    chk("overflow", f, range_overflow_flag);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CTRL_OFFS, 32'h0000_0004);
    chk("visible", 1, parameter_visible);
    rdc(AGAIN_OFFS, 32'h0000_0001);
    rdc(BAND_OFFS, 32'h0000_0000);
    wr(CONNECT_OFFS, 32'h0000_0008);
    wr(BAND_OFFS, 32'd10);
    wr(SETPOINT_OFFS, 32'd100);
    step(32'd120, 0, 0);
    step(32'd100, 1, 0);
    step(32'd105, 1, 0);
    step(32'd111, 0, 0);
    step(32'd105, 0, 0);
    wr(CTRL_OFFS, 32'h0000_0005);
    step(32'd80, 0, 0);
    step(32'd100, 1, 0);
    step(32'd95, 1, 0);
    step(32'd89, 0, 0);
    wr(CTRL_OFFS, 32'h0000_0006);
    step(32'd95, 0, 0);
    step(32'd100, 1, 0);
    step(32'd109, 1, 0);
    step(32'd111, 0, 0);
    step(32'd100, 1, 0);
    step(32'd89, 0, 0);
    wr(CTRL_OFFS, 32'h0000_0005);
    wr(CONNECT_OFFS, 32'h0000_000f);
    wr(AGAIN_OFFS, 32'd3);
    wr(SGAIN_OFFS, 32'd2);
    wr(OFFSET_OFFS, 32'hffff_ffec);
    wr(SETPOINT_OFFS, 32'd50);
    step(32'd40, 1, 0);
    rdc(PROC_ACT_OFFS, 32'd100);
    rdc(PROC_SET_OFFS, 32'd100);
    step(32'd36, 0, 0);
    wr(AGAIN_OFFS, 32'd2);
    wr(OFFSET_OFFS, 32'h0000_0000);
    step(32'h4000_0000, 0, 1);
    wr(OFFSET_OFFS, 32'hffff_ffff);
    step(32'h4000_0000, 1, 0);
    wr(SGAIN_OFFS, 32'd1);
    wr(SETPOINT_OFFS, 32'h7fff_fff8);
    step(32'h4000_0000, 0, 1);
    wr(SETPOINT_OFFS, 32'd0);
    repeat (3) @(posedge pclk);
    chk("held flag", 1, range_overflow_flag);
    wr(CTRL_OFFS, 32'h0000_0001);
    @(negedge pclk);
    chk("visible", 0, parameter_visible);
    step(32'd1, 1, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset contact", 0, compare_result_contact);
    chk("reset flag", 0, range_overflow_flag);
    chk("reset visible", 1, parameter_visible);
    rdc(CTRL_OFFS, 32'h0000_0004);
    apb(1'b0, 8'h30, '0);
    chk("unmapped error", 1, er);
    chk("unmapped data", 0, rd);
    apb(1'b1, STATUS_OFFS, 32'h0000_0007);
    chk("read-only error", 1, er);
    end_sim();
  end
  initial begin
    #200000;
    chk("run timeout", 1, 0);
    end_sim();
  end
endmodule
bind scaled_threshold_comparator threshold_cmp_properties u_props (
  .pclk                   (pclk),
  .presetn                (presetn),
  .psel                   (psel),
  .penable                (penable),
  .pwrite                 (pwrite),
  .paddr                  (paddr),
  .pwdata                 (pwdata),
  .pstrb                  (pstrb),
  .prdata                 (prdata),
  .pready                 (pready),
  .pslverr                (pslverr),
  .scan_strobe            (scan_strobe),
  .compare_result_contact (compare_result_contact),
  .range_overflow_flag    (range_overflow_flag),
  .parameter_visible      (parameter_visible)
);
